//--- verilog/mag_regs.svh
// Offsets, field positions, reset values and timing counts of the
// magnetometer register bank. Definitions only; included by bare name.
`ifndef MAG_REGS_SVH
`define MAG_REGS_SVH

// ==================================================================
// Clock
`define REF_CLK_HZ      20000000

// ==================================================================
// Register offsets
`define ADR_CFG_A       8'h00
`define ADR_CFG_B       8'h01
`define ADR_MODE        8'h02
`define ADR_DATA_FIRST  8'h03
`define ADR_DATA_LAST   8'h08
`define ADR_STATUS      8'h09
`define ADR_ID_A        8'h0A
`define ADR_ID_B        8'h0B
`define ADR_ID_C        8'h0C

// ==================================================================
// Reset values and writable bits
`define CFG_A_RESET     8'h10
`define CFG_B_RESET     8'h20
`define MODE_RESET      8'h02
`define CFG_A_WMASK     8'h1F
`define CFG_B_WMASK     8'hEF
`define MODE_WMASK      8'h03

// ==================================================================
// Field positions
`define RATE_MSB        4
`define RATE_LSB        2
`define BIAS_MSB        1
`define BIAS_LSB        0
`define STATUS_RDY      0

// ==================================================================
// Timing
`define TURNON_US       100
`define TURNON_CYC      ((`TURNON_US) * (`REF_CLK_HZ / 1000000))
`define CONV_US         5
`define CONV_CYC        ((`CONV_US) * (`REF_CLK_HZ / 1000000))
`define PER_R0_MS       2000
`define PER_R1_MS       1000
`define PER_R2_MS       500
`define PER_R3_MS       200
`define PER_R4_MS       100
`define PER_R5_MS       50
`define PER_R6_MS       20
`define CYC_PER_MS      (`REF_CLK_HZ / 1000)

`endif

//--- verilog/mag_pkg.sv
// Types of the magnetometer register bank.
// Assumes mag_regs.svh for numeric constants.
package mag_pkg;

   // ===============================================================
   // Enumerations
   typedef enum logic [3:0] {
      I_IDLE, I_ADDR, I_AACK, I_PTR, I_PACK,
      I_WDATA, I_WACK, I_RDATA, I_RACK
   } i2c_state_type;

   typedef enum logic [1:0] {
      M_IDLE, M_TURNON, M_CONV
   } meas_state_type;

   typedef enum logic [1:0] {
      MODE_CONT, MODE_SINGLE, MODE_IDLE, MODE_SLEEP
   } mode_type;

   // ===============================================================
   // Whole state of the bank
   typedef struct packed {
      logic [2:0]      scl_s;
      logic [2:0]      sda_s;
      logic            scl_f;
      logic            sda_f;
      i2c_state_type   is;
      logic [3:0]      bits;
      logic [7:0]      sh;
      logic            rw;
      logic            ack_ok;
      logic            sda_oe;
      logic            sda_o;
      logic [7:0]      ptr;
      logic [7:0]      cfg_a;
      logic [7:0]      cfg_b;
      logic [7:0]      mode;
      logic [5:0][7:0] data;
      logic            rdy;
      meas_state_type  ms;
      logic [25:0]     per_cnt;
      logic [11:0]     cnt;
      logic            ph;
      logic [1:0]      axis;
      logic [11:0]     samp;
      logic            analog_en;
      logic            sr_set;
      logic            bpos_oe;
      logic            bneg_oe;
      logic            bpos_o;
      logic            bneg_o;
   } state_type;

endpackage : mag_pkg

//--- verilog/magnetometer_register_access.sv
// Register bank of a three-axis magnetic sensor behind a two-wire
// serial slave, with rate timer and measurement sequencer.
// Assumes an open-drain bus resolved outside; SCL below 1/6 of clock.
`include "mag_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module magnetometer_register_access #(
   parameter logic [6:0] DEV_ADDR = 7'h2A,
   // Identification bytes; values are arbitrary
   parameter logic [7:0] ID_A     = 8'h5A,
   parameter logic [7:0] ID_B     = 8'h3C,
   parameter logic [7:0] ID_C     = 8'h66,
   parameter int unsigned RATE_CYC [7] = '{
      `PER_R0_MS * `CYC_PER_MS, `PER_R1_MS * `CYC_PER_MS,
      `PER_R2_MS * `CYC_PER_MS, `PER_R3_MS * `CYC_PER_MS,
      `PER_R4_MS * `CYC_PER_MS, `PER_R5_MS * `CYC_PER_MS,
      `PER_R6_MS * `CYC_PER_MS}
) (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   // Serial bus pins
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output var  logic        o_sda_o,
   output var  logic        o_sda_oe,
   // Analog front end
   input  wire logic [11:0] i_adc_sample,
   output var  logic [1:0]  o_axis_sel,
   output var  logic        o_analog_en,
   output var  logic        o_sr_set,
   // Bias strap pins
   output var  logic        o_bias_strap_pos_o,
   output var  logic        o_bias_strap_pos_oe,
   output var  logic        o_bias_strap_neg_o,
   output var  logic        o_bias_strap_neg_oe
);

   // ===============================================================
   // Reset release
   logic [1:0] rst_sync_q;
   logic       rst_n_q;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n_q = rst_sync_q[1];

   // ===============================================================
   // Decoding helpers
   mag_pkg::state_type q;
   mag_pkg::state_type d;

   function automatic logic [7:0] next_ptr(input logic [7:0] p);
      if (p == `ADR_DATA_LAST) begin
         next_ptr = `ADR_DATA_FIRST;
      end else if (p >= `ADR_ID_C) begin
         next_ptr = 8'h00;
      end else begin
         next_ptr = p + 8'h01;
      end
   endfunction : next_ptr

   // No location returns the pointer itself
   function automatic logic [7:0] rd_byte(input mag_pkg::state_type s);
      logic [7:0] idx;
      idx = s.ptr - `ADR_DATA_FIRST;
      case (s.ptr)
         `ADR_CFG_A:  rd_byte = s.cfg_a;
         `ADR_CFG_B:  rd_byte = s.cfg_b;
         `ADR_MODE:   rd_byte = s.mode;
         `ADR_STATUS: rd_byte = {7'h00, s.rdy};
         `ADR_ID_A:   rd_byte = ID_A;
         `ADR_ID_B:   rd_byte = ID_B;
         `ADR_ID_C:   rd_byte = ID_C;
         default: begin
            if (s.ptr >= `ADR_DATA_FIRST && s.ptr <= `ADR_DATA_LAST) begin
               rd_byte = s.data[idx[2:0]];
            end else begin
               rd_byte = 8'h00;
            end
         end
      endcase
   endfunction : rd_byte

   // ===============================================================
   // Next state
   logic        nscl;
   logic        nsda;
   logic        scl_r;
   logic        scl_fl;
   logic        bus_start;
   logic        bus_stop;
   logic        do_load;
   logic        ptr_adv;
   logic        restart;
   logic        meas_done;
   logic        go;
   logic        normal;
   logic [2:0]  rate;
   logic [7:0]  rbyte;
   logic [12:0] diff;
   logic [11:0] res;
   mag_pkg::mode_type mode;

   always_comb begin
      d         = q;
      do_load   = 1'b0;
      ptr_adv   = 1'b0;
      restart   = 1'b0;
      meas_done = 1'b0;
      go        = 1'b0;
      rbyte     = rd_byte(q);
      // Change counts once the last two stages agree
      d.scl_s   = {q.scl_s[1:0], i_scl};
      d.sda_s   = {q.sda_s[1:0], i_sda};
      nscl      = (q.scl_s[1] == q.scl_s[2]) ? q.scl_s[2] : q.scl_f;
      nsda      = (q.sda_s[1] == q.sda_s[2]) ? q.sda_s[2] : q.sda_f;
      d.scl_f   = nscl;
      d.sda_f   = nsda;
      scl_r     = nscl & ~q.scl_f;
      scl_fl    = ~nscl & q.scl_f;
      bus_start = nscl & q.scl_f & q.sda_f & ~nsda;
      bus_stop  = nscl & q.scl_f & ~q.sda_f & nsda;

      // ============================================================
      // Serial slave
      if (bus_start) begin
         d.is     = mag_pkg::I_ADDR;
         d.bits   = 4'h0;
         d.sda_oe = 1'b0;
      end else if (bus_stop) begin
         d.is     = mag_pkg::I_IDLE;
         d.sda_oe = 1'b0;
      end else if (scl_r) begin
         if (q.is inside {mag_pkg::I_ADDR, mag_pkg::I_PTR,
                          mag_pkg::I_WDATA} && q.bits < 4'h8) begin
            d.sh   = {q.sh[6:0], nsda};
            d.bits = q.bits + 4'h1;
         end
         if (q.is == mag_pkg::I_RACK) begin
            d.ack_ok = ~nsda;
         end
      end else if (scl_fl) begin
         unique case (q.is)
            mag_pkg::I_IDLE: begin
            end
            mag_pkg::I_ADDR: begin
               if (q.bits == 4'h8) begin
                  if (q.sh[7:1] == DEV_ADDR) begin
                     d.is     = mag_pkg::I_AACK;
                     d.rw     = q.sh[0];
                     d.sda_oe = 1'b1;
                  end else begin
                     d.is = mag_pkg::I_IDLE;
                  end
               end
            end
            mag_pkg::I_AACK: begin
               d.sda_oe = 1'b0;
               d.bits   = 4'h0;
               if (q.rw) begin
                  do_load = 1'b1;
               end else begin
                  d.is = mag_pkg::I_PTR;
               end
            end
            mag_pkg::I_PTR: begin
               if (q.bits == 4'h8) begin
                  // Pointer alone touches no register
                  d.ptr    = q.sh;
                  d.is     = mag_pkg::I_PACK;
                  d.sda_oe = 1'b1;
               end
            end
            mag_pkg::I_PACK, mag_pkg::I_WACK: begin
               d.is     = mag_pkg::I_WDATA;
               d.bits   = 4'h0;
               d.sda_oe = 1'b0;
            end
            mag_pkg::I_WDATA: begin
               if (q.bits == 4'h8) begin
                  d.is     = mag_pkg::I_WACK;
                  d.sda_oe = 1'b1;
                  ptr_adv  = 1'b1;
                  case (q.ptr)
                     `ADR_CFG_A: begin
                        d.cfg_a = q.sh & `CFG_A_WMASK;
                        restart = 1'b1;
                     end
                     `ADR_CFG_B: begin
                        d.cfg_b = q.sh & `CFG_B_WMASK;
                     end
                     `ADR_MODE: begin
                        d.mode  = q.sh & `MODE_WMASK;
                        restart = 1'b1;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            mag_pkg::I_RDATA: begin
               if (q.bits == 4'h8) begin
                  d.is     = mag_pkg::I_RACK;
                  d.sda_oe = 1'b0;
               end else begin
                  d.sh     = {q.sh[6:0], 1'b0};
                  d.sda_oe = ~q.sh[6];
                  d.bits   = q.bits + 4'h1;
               end
            end
            mag_pkg::I_RACK: begin
               if (q.ack_ok) begin
                  do_load = 1'b1;
               end else begin
                  d.is = mag_pkg::I_IDLE;
               end
            end
         endcase
      end

      if (do_load) begin
         d.is     = mag_pkg::I_RDATA;
         d.sh     = rbyte;
         d.sda_oe = ~rbyte[7];
         d.bits   = 4'h1;
         ptr_adv  = 1'b1;
         if (q.ptr >= `ADR_DATA_FIRST && q.ptr <= `ADR_DATA_LAST) begin
            d.rdy = 1'b0;
         end
      end
      if (ptr_adv) begin
         d.ptr = next_ptr(q.ptr);
      end

      // ============================================================
      // Rate timer
      mode   = mag_pkg::mode_type'(d.mode[1:0]);
      rate   = d.cfg_a[`RATE_MSB:`RATE_LSB];
      normal = d.cfg_a[`BIAS_MSB:`BIAS_LSB] == 2'b00;
      // Unused code 111 runs at the default rate
      if (rate == 3'h7) begin
         rate = 3'h4;
      end
      if (restart || mode != mag_pkg::MODE_CONT) begin
         d.per_cnt = 26'h0;
         if (restart) begin
            d.ms = mag_pkg::M_IDLE;
         end
      end else if (q.per_cnt == 26'h0) begin
         d.per_cnt = 26'(RATE_CYC[rate] - 1);
         go        = 1'b1;
      end else begin
         d.per_cnt = q.per_cnt - 26'h1;
      end
      if (mode == mag_pkg::MODE_SINGLE) begin
         go = 1'b1;
      end

      // ============================================================
      // Measurement sequencer
      diff = {q.samp[11], q.samp} - {i_adc_sample[11], i_adc_sample};
      res  = normal ? diff[12:1] : i_adc_sample;
      if (!restart) begin
         unique case (q.ms)
            mag_pkg::M_IDLE: begin
               if (go) begin
                  d.ms   = mag_pkg::M_TURNON;
                  d.cnt  = 12'h0;
                  d.axis = 2'h0;
                  d.ph   = 1'b0;
               end
            end
            mag_pkg::M_TURNON: begin
               if (q.cnt == 12'(`TURNON_CYC - 1)) begin
                  d.ms  = mag_pkg::M_CONV;
                  d.cnt = 12'h0;
               end else begin
                  d.cnt = q.cnt + 12'h1;
               end
            end
            mag_pkg::M_CONV: begin
               if (q.cnt != 12'(`CONV_CYC - 1)) begin
                  d.cnt = q.cnt + 12'h1;
               end else if (normal && !q.ph) begin
                  d.cnt  = 12'h0;
                  d.samp = i_adc_sample;
                  d.ph   = 1'b1;
               end else begin
                  d.cnt = 12'h0;
                  d.ph  = 1'b0;
                  d.data[{q.axis, 1'b0}] = {{4{res[11]}}, res[11:8]};
                  d.data[{q.axis, 1'b1}] = res[7:0];
                  if (q.axis == 2'h2) begin
                     d.ms      = mag_pkg::M_IDLE;
                     meas_done = 1'b1;
                     if (mode == mag_pkg::MODE_SINGLE) begin
                        d.mode[1:0] = 2'(mag_pkg::MODE_SLEEP);
                     end
                  end else begin
                     d.axis = q.axis + 2'h1;
                  end
               end
            end
            default: begin
               d.ms = mag_pkg::M_IDLE;
            end
         endcase
      end
      // New data beats a same-cycle read clear
      if (meas_done) begin
         d.rdy = 1'b1;
      end

      // ============================================================
      // Registered pin drive
      d.analog_en = d.ms != mag_pkg::M_IDLE;
      d.sr_set    = d.analog_en && normal && !d.ph;
      d.bpos_oe   = d.analog_en && (d.cfg_a[1:0] == 2'b01 ||
                                    d.cfg_a[1:0] == 2'b10);
      d.bneg_oe   = d.bpos_oe;
      d.bpos_o    = d.cfg_a[1:0] == 2'b01;
      d.bneg_o    = d.cfg_a[1:0] == 2'b10;
   end

   // ===============================================================
   // State register
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         q       <= '0;
         q.scl_s <= 3'h7;
         q.sda_s <= 3'h7;
         q.scl_f <= 1'b1;
         q.sda_f <= 1'b1;
         q.cfg_a <= `CFG_A_RESET;
         q.cfg_b <= `CFG_B_RESET;
         q.mode  <= `MODE_RESET;
      end else begin
         q <= d;
      end
   end

   assign o_sda_o             = q.sda_o;
   assign o_sda_oe            = q.sda_oe;
   assign o_axis_sel          = q.axis;
   assign o_analog_en         = q.analog_en;
   assign o_sr_set            = q.sr_set;
   assign o_bias_strap_pos_o  = q.bpos_o;
   assign o_bias_strap_pos_oe = q.bpos_oe;
   assign o_bias_strap_neg_o  = q.bneg_o;
   assign o_bias_strap_neg_oe = q.bneg_oe;

   // ===============================================================
   // Checks
   AST_PTR_WRAP_DATA: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      (ptr_adv && q.ptr == `ADR_DATA_LAST) |=> q.ptr == `ADR_DATA_FIRST)
      else $error("pointer did not wrap from 08 to 03");
   AST_PTR_WRAP_TOP: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      (ptr_adv && q.ptr >= `ADR_ID_C) |=> q.ptr == 8'h00)
      else $error("pointer did not wrap to 0");
   AST_PTR_STEP: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      (ptr_adv && q.ptr < `ADR_ID_C && q.ptr != `ADR_DATA_LAST)
      |=> q.ptr == $past(q.ptr) + 8'h01)
      else $error("pointer did not step by one");
   AST_CFG_UPPER_ZERO: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      q.cfg_a[7:5] == 3'h0 && q.cfg_b[4] == 1'b0 && q.mode[7:2] == 6'h0)
      else $error("undefined config bit set");
   AST_RESET_CFG: assert property (
      @(posedge i_ref_clk) disable iff (!i_arst_n)
      (!$past(rst_n_q) && rst_n_q) |-> q.cfg_a == `CFG_A_RESET)
      else $error("rate/bias config wrong after reset");
   AST_BIAS_FLOAT: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      (o_bias_strap_pos_oe || o_bias_strap_neg_oe)
      |-> q.cfg_a[1:0] != 2'b00 && q.ms != mag_pkg::M_IDLE)
      else $error("strap driven in normal flow");
   AST_TURNON_FIRST: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      (q.ms == mag_pkg::M_IDLE ##1 q.ms == mag_pkg::M_TURNON)
      |-> q.ms == mag_pkg::M_TURNON [*8])
      else $error("conversion began before turn-on");
   AST_SINGLE_SLEEP: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      (meas_done && !restart && q.mode[1:0] == 2'b01)
      |=> q.mode[1:0] == 2'b11 && !o_analog_en)
      else $error("single run did not drop to sleep");
   AST_READY_SET: assert property (
      @(posedge i_ref_clk) disable iff (!rst_n_q)
      meas_done |=> q.rdy && q.ms == mag_pkg::M_IDLE)
      else $error("ready not set after three axes");

endmodule : magnetometer_register_access
`default_nettype wire

//--- verif/i2c_host_model.sv
// Two-wire bus master model: drives SCL, pulls SDA low or releases it.
// Assumes a pull-up resolves SDA outside; each SCL phase of a data bit is 10 clocks.
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model (
   // Clock and resolved data line
   input  wire logic i_clk,
   input  wire logic i_sda,
   // Driven lines
   output var  logic o_scl,
   output var  logic o_sda_low
);
   initial begin
      o_scl     = 1'b1;
      o_sda_low = 1'b0;
   end

   // ==============================================================
   // Bit level; lines move only a fixed delay after a clock edge
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #5;
   endtask : tick

   task automatic start_c();
      o_sda_low = 1'b0;
      tick(5);
      o_scl = 1'b1;
      tick(10);
      o_sda_low = 1'b1;
      tick(10);
      o_scl = 1'b0;
      tick(5);
   endtask : start_c

   task automatic stop_c();
      o_sda_low = 1'b1;
      tick(5);
      o_scl = 1'b1;
      tick(10);
      o_sda_low = 1'b0;
      tick(10);
   endtask : stop_c

   // Data only changes while SCL is low, so no false START or STOP
   task automatic bit_x(input logic b, output logic r);
      o_sda_low = ~b;
      tick(5);
      o_scl = 1'b1;
      tick(8);
      r = i_sda;
      tick(2);
      o_scl = 1'b0;
      tick(5);
   endtask : bit_x

   // ==============================================================
   // Byte level
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(b[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask : put_byte

   task automatic get_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         b[i] = r;
      end
      bit_x(last, r);
   endtask : get_byte
endmodule : i2c_host_model
`default_nettype wire

//--- verif/magnetometer_register_access_tb.sv
// Self-checking bench for the magnetometer register bank.
// Assumes default device address and identification parameters.
`include "mag_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module magnetometer_register_access_tb;
   localparam logic [6:0] ADDR = 7'h2A;
   logic        clk    = 1'b0;
   logic        arst_n = 1'b0;
   logic [11:0] adc    = 12'h000;
   logic        scl, m_low, sda_o, sda_oe, an_en, sr_set;
   logic        bp_o, bp_oe, bn_o, bn_oe;
   logic [1:0]  axis;
   wire  logic  sda    = ~(m_low | (sda_oe & ~sda_o));
   int          fail_count = 0;
   int          n_tests    = 0;

   always #25 clk = ~clk;

   magnetometer_register_access DUT (
      .i_ref_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda),
      .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_adc_sample(adc),
      .o_axis_sel(axis), .o_analog_en(an_en), .o_sr_set(sr_set),
      .o_bias_strap_pos_o(bp_o), .o_bias_strap_pos_oe(bp_oe),
      .o_bias_strap_neg_o(bn_o), .o_bias_strap_neg_oe(bn_oe));

   i2c_host_model m (.i_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(m_low));

   // ==============================================================
   // Compare and bus tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] p, input logic [7:0] d,
                     input bit dat);
      logic a;
      m.start_c();
      m.put_byte({ADDR, 1'b0}, a);
      chk({7'h0, a}, 8'h01);
      m.put_byte(p, a);
      chk({7'h0, a}, 8'h01);
      if (dat) begin
         m.put_byte(d, a);
         chk({7'h0, a}, 8'h01);
      end
      m.stop_c();
   endtask : wr

   task automatic rd(input logic [7:0] p, input int n,
                     input logic [63:0] e);
      logic [7:0] b;
      logic       a;
      wr(p, 8'h00, 1'b0);
      m.start_c();
      m.put_byte({ADDR, 1'b1}, a);
      chk({7'h0, a}, 8'h01);
      for (int i = 0; i < n; i++) begin
         m.get_byte(i == n - 1, b);
         chk(b, e[8*(n-1-i) +: 8]);
      end
      m.stop_c();
   endtask : rd

   // ==============================================================
   // Scenarios
   task automatic t_reset_map();
      rd(8'h00, 3, {`CFG_A_RESET, `CFG_B_RESET, `MODE_RESET});
      rd(8'h09, 5, {8'h00, 8'h5A, 8'h3C, 8'h66, `CFG_A_RESET});
   endtask : t_reset_map

   task automatic t_invalid();
      logic a;
      rd(8'h0D, 2, {8'h00, `CFG_A_RESET});
      wr(8'h03, 8'h55, 1'b1);
      wr(8'h20, 8'hAA, 1'b1);
      // Upper bits set on purpose to see them dropped
      wr(8'h00, 8'hE4, 1'b1);
      rd(8'h03, 1, 64'h0);
      rd(8'h00, 3, {8'h04, `CFG_B_RESET, `MODE_RESET});
      wr(8'h00, `CFG_A_RESET, 1'b1);
      m.start_c();
      m.put_byte({ADDR ^ 7'h01, 1'b0}, a);
      chk({7'h0, a}, 8'h00);
      m.stop_c();
   endtask : t_invalid

   // Single run; strap state looked at well inside the conversions
   task automatic t_meas(input logic [1:0] bias, input logic [11:0] s);
      logic [7:0] hi;
      logic [7:0] lo;
      int         k;
      hi  = (bias == 2'b00) ? 8'h00 : {{4{s[11]}}, s[11:8]};
      lo  = (bias == 2'b00) ? 8'h00 : s[7:0];
      adc = s;
      wr(8'h00, {6'h04, bias}, 1'b1);
      wr(8'h02, 8'h01, 1'b1);
      k = 0;
      while (an_en !== 1'b1 && k < 3000) begin
         @(posedge clk);
         #5;
         k++;
      end
      // Turn-on began a few dozen clocks before the bus write returned
      repeat (2000) @(posedge clk);
      #5;
      chk({3'h0, an_en, bp_oe, bn_oe, {bp_o, bn_o} & {2{|bias}}},
          {3'h1, {2{|bias}}, bias == 2'b01, bias == 2'b10});
      chk({5'h0, sr_set, axis}, {5'h0, bias == 2'b00, 2'h0});
      repeat (100) @(posedge clk);
      #5;
      chk({5'h0, sr_set, axis},
          {6'h00, (bias == 2'b00) ? 2'h0 : 2'h1});
      k = 0;
      while (an_en !== 1'b0 && k < 1000) begin
         @(posedge clk);
         #5;
         k++;
      end
      chk({5'h0, an_en, bp_oe, bn_oe}, 8'h00);
      rd(8'h02, 1, 64'h03);
      rd(8'h09, 1, 64'h01);
      rd(8'h03, 8, {4{hi, lo}});
   endtask : t_meas

   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // ==============================================================
   // Main sequence and watchdog
   initial begin
      repeat (5) @(posedge clk);
      #5;
      arst_n = 1'b1;
      repeat (6) @(posedge clk);
      #5;
      t_reset_map();
      t_invalid();
      t_meas(2'b00, 12'h123);
      t_meas(2'b01, 12'h123);
      t_meas(2'b10, 12'hF85);
      print_verdict();
   end

   // About two and a half times the expected run length
   initial begin
      #4_000_000;
      fail_count++;
      print_verdict();
   end
endmodule : magnetometer_register_access_tb
`default_nettype wire
